// >>> hw/fepc_consts.svh
// offsets, field positions and reset values of the event pin configuration block
// assumes a 32-bit ahb-lite slot with each register in one aligned word
`ifndef FEPC_CONSTS_SVH
`define FEPC_CONSTS_SVH

`define FEPC_CFG_OFS      8'h00
`define FEPC_REC_OFS      8'h04
`define FEPC_MASK_OFS     8'h08
`define FEPC_PIN_OFS      8'h0c

`define FEPC_PIN_DIS_BIT  7
`define FEPC_READY_BIT    4
`define FEPC_DERR_BIT     1
`define FEPC_SERR_BIT     0

`define FEPC_EVT_BITS     8'h13
`define FEPC_CFG_RSVD     8'h6c
`define FEPC_REC_RSVD     8'hec

`define FEPC_CFG_RST      8'hff
`define FEPC_REC_RST      8'hff
`define FEPC_MASK_RST     8'h00
`define FEPC_PIN_RST      1'b1

`define FEPC_HRESP_OKAY   1'b0
`define FEPC_HTRANS_NSEQ  2'h2

`endif

// >>> hw/fepc_pkg.sv
// types shared by the event pin configuration block
// assumes the constants header is included by its users
package fepc_pkg;

	typedef logic [7:0] fepc_byte_t;

	typedef enum logic [0:0] {
		FEPC_BUS_IDLE,
		FEPC_BUS_RWAIT
	} fepc_bus_state_t;

endpackage

// >>> hw/fepc_sync.sv
// three-stage synchroniser with agreement filter for one pin level
// assumes the pin is asynchronous to hclk
`timescale 1ns/1ps
`default_nettype none

module fepc_sync (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic async_in,
	output logic      level_q
);

	logic meta_q;
	logic stage2_q;
	logic stage3_q;
	wire  agree = (stage2_q == stage3_q);

	// the first stage feeds only the second, so metastability stays contained
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_q   <= 1'b1;
			stage2_q <= 1'b1;
			stage3_q <= 1'b1;
			level_q  <= 1'b1;
		end else begin
			meta_q   <= async_in;
			stage2_q <= meta_q;
			stage3_q <= stage2_q;
			if (agree) begin
				level_q <= stage3_q;
			end
		end
	end

endmodule

`default_nettype wire

// >>> hw/fepc_top.sv
// event pin configuration block: event recording, open-drain event pin, ahb-lite registers
// assumes event inputs come from logic on hclk; the pin itself is resolved outside
//
// Behaviour
// - the event pin is pulled low only because of an event whose source is selected.
// - the event pin is open-drain: it is either driven low or released, never driven high.
// - a disabled source never updates its bit in the event record.
// - writing the configuration leaves the event record untouched.
// - configuration bit 7 at 0 enables the pin function, at 1 disables it, reset value 1.
// - with bit 4 at 0 a busy-to-ready transition asserts the pin, at 1 it does not.
// - with bit 1 at 0 a double-bit array error asserts the pin, at 1 it does not.
// - with bit 0 at 0 a corrected single-bit error asserts the pin, at 1 it does not.
// - each enabled event clears its record bit 4, 1 or 0 to 0, all record bits reset to 1.
//
// Chosen here: the register offsets and the AHB-Lite register port.
`include "fepc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module fepc_top (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        busy_in,
	input  wire logic        double_err_evt,
	input  wire logic        single_err_evt,
	input  wire logic        event_pin_in,
	output logic             event_pin_out,
	output logic             event_pin_oe_n,
	output logic             irq
);

	import fepc_pkg::*;

	fepc_bus_state_t state_q;
	fepc_bus_state_t state_d;
	fepc_byte_t      cfg_q;
	fepc_byte_t      rec_q;
	fepc_byte_t      rec_d;
	fepc_byte_t      mask_q;
	logic [7:0]      addr_q;
	logic            wr_pend_q;
	logic            busy_q;
	logic [31:0]     hrdata_q;
	logic            hreadyout_q;
	logic            oe_n_q;
	logic            irq_q;
	logic            pin_level_q;

	// pin level readback, asynchronous to hclk
	fepc_sync u_pin_sync (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.async_in (event_pin_in),
		.level_q  (pin_level_q)
	);

	// bus address phase decode
	wire        accept   = hsel && hready && (htrans == `FEPC_HTRANS_NSEQ);
	wire        rd_start = accept && !hwrite;
	wire        wr_start = accept && hwrite;
	wire        wr_cfg   = wr_pend_q && (addr_q == `FEPC_CFG_OFS);
	wire        wr_rec   = wr_pend_q && (addr_q == `FEPC_REC_OFS);
	wire        wr_mask  = wr_pend_q && (addr_q == `FEPC_MASK_OFS);
	wire [7:0]  wbyte    = hwdata[7:0];

	// unmapped offsets read as zero and drop writes
	wire [31:0] rd_mux =
		(addr_q == `FEPC_CFG_OFS)  ? {24'h000000, cfg_q}  :
		(addr_q == `FEPC_REC_OFS)  ? {24'h000000, rec_q}  :
		(addr_q == `FEPC_MASK_OFS) ? {24'h000000, mask_q} :
		(addr_q == `FEPC_PIN_OFS)  ? {31'h00000000, pin_level_q} :
		32'h00000000;

	// event sources
	wire       ready_evt = busy_q && !busy_in;
	wire [7:0] evt_vec   = {3'h0, ready_evt, 2'h0, double_err_evt, single_err_evt};
	// a source counts only while its configuration bit is 0
	wire [7:0] src_on    = ~cfg_q & `FEPC_EVT_BITS;
	wire [7:0] evt_on    = evt_vec & src_on;
	wire [7:0] occurred  = ~rec_q & `FEPC_EVT_BITS;
	wire       fn_on     = !cfg_q[`FEPC_PIN_DIS_BIT];
	wire       pin_hit   = fn_on && |(occurred & src_on);
	wire       irq_hit   = |(occurred & mask_q);

	// write-one restores a bit to 1; an event in the same cycle wins and holds it at 0
	wire [7:0] rec_clr   = wr_rec ? (wbyte & `FEPC_EVT_BITS) : 8'h00;
	always_comb begin
		rec_d = (rec_q | rec_clr) & ~evt_on;
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			FEPC_BUS_IDLE: begin
				if (rd_start) begin
					state_d = FEPC_BUS_RWAIT;
				end
			end
			FEPC_BUS_RWAIT: begin
				state_d = FEPC_BUS_IDLE;
			end
			default: begin
				state_d = FEPC_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q   <= FEPC_BUS_IDLE;
			addr_q    <= 8'h00;
			wr_pend_q <= 1'b0;
		end else begin
			state_q   <= state_d;
			wr_pend_q <= wr_start;
			if (accept) begin
				addr_q <= {haddr[7:2], 2'h0};
			end
		end
	end

	// one wait state on reads so a write just before is already visible
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout_q <= 1'b1;
			hrdata_q    <= 32'h00000000;
		end else begin
			hreadyout_q <= !rd_start;
			if (state_q == FEPC_BUS_RWAIT) begin
				hrdata_q <= rd_mux;
			end
		end
	end

	// reserved configuration bits keep whatever the host writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_q  <= `FEPC_CFG_RST;
			mask_q <= `FEPC_MASK_RST;
		end else begin
			if (wr_cfg) begin
				cfg_q <= wbyte;
			end
			if (wr_mask) begin
				mask_q <= wbyte & `FEPC_EVT_BITS;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rec_q  <= `FEPC_REC_RST;
			busy_q <= 1'b0;
		end else begin
			rec_q  <= rec_d;
			busy_q <= busy_in;
		end
	end

	// the pin data is tied low in a flop, only the enable moves
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			oe_n_q <= 1'b1;
			irq_q  <= 1'b0;
		end else begin
			oe_n_q <= !pin_hit;
			irq_q  <= irq_hit;
		end
	end

	logic pin_out_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_out_q <= 1'b0;
		end else begin
			pin_out_q <= 1'b0;
		end
	end

	logic hresp_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp_q <= `FEPC_HRESP_OKAY;
		end else begin
			hresp_q <= `FEPC_HRESP_OKAY;
		end
	end

	assign hrdata         = hrdata_q;
	assign hreadyout      = hreadyout_q;
	assign hresp          = hresp_q;
	assign event_pin_out  = pin_out_q;
	assign event_pin_oe_n = oe_n_q;
	assign irq            = irq_q;

	a_pin_cause: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(oe_n_q) |-> $past(fn_on && |(occurred & src_on)))
		else $error("event pin pulled low without a selected event");

	a_pin_never_high: assert property (@(posedge hclk) disable iff (!hresetn)
		!pin_out_q)
		else $error("event pin data is not low");

	a_off_src_kept: assert property (@(posedge hclk) disable iff (!hresetn)
		1'b1 |=> (($past(cfg_q & rec_q) & ~rec_q & `FEPC_EVT_BITS) == 8'h00))
		else $error("disabled source changed its record bit");

	a_cfg_keeps_rec: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_cfg && (evt_vec == 8'h00) |=> rec_q == $past(rec_q))
		else $error("configuration write altered the event record");

	a_fn_off_release: assert property (@(posedge hclk) disable iff (!hresetn)
		cfg_q[`FEPC_PIN_DIS_BIT] |=> oe_n_q)
		else $error("event pin driven while the function is disabled");

	a_ready_record: assert property (@(posedge hclk) disable iff (!hresetn)
		!cfg_q[`FEPC_READY_BIT] && busy_q && !busy_in |=> !rec_q[`FEPC_READY_BIT])
		else $error("busy-to-ready transition not recorded");

	a_double_record: assert property (@(posedge hclk) disable iff (!hresetn)
		!cfg_q[`FEPC_DERR_BIT] && double_err_evt |=> !rec_q[`FEPC_DERR_BIT] ##1 !oe_n_q
		|| $past(cfg_q[`FEPC_PIN_DIS_BIT]) || $past(cfg_q[`FEPC_DERR_BIT]))
		else $error("double-bit error not recorded or pin not asserted");

	a_single_record: assert property (@(posedge hclk) disable iff (!hresetn)
		!cfg_q[`FEPC_SERR_BIT] && single_err_evt |=> !rec_q[`FEPC_SERR_BIT])
		else $error("single-bit error not recorded");

	a_rec_rsvd_ones: assert property (@(posedge hclk) disable iff (!hresetn)
		(rec_q & `FEPC_REC_RSVD) == `FEPC_REC_RSVD)
		else $error("reserved record bits not at one");

	a_pin_holds: assert property (@(posedge hclk) disable iff (!hresetn)
		pin_hit ##1 pin_hit |-> !oe_n_q)
		else $error("event pin released while an enabled event stands");

	a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_start |=> !hreadyout_q ##1 hreadyout_q)
		else $error("read answer not after exactly one wait state");

endmodule

`default_nettype wire

// >>> testbench/fepc_host_model.sv
// host side of the event pin: pull-up and the level its interrupt input sees
// assumes the device only ever sinks the line
`timescale 1ns/1ps
`default_nettype none

module fepc_host_model (
	input  wire logic pin_out,
	input  wire logic pin_oe_n,
	output logic      pin_level
);
	// released line floats to the pull-up, never to a stale value
	assign pin_level = pin_oe_n ? 1'b1 : pin_out;
endmodule
`default_nettype wire

// >>> testbench/fepc_top_tb.sv
// self-checking bench for the event pin configuration block
// assumes one ahb-lite slave, so hready is the slave's hreadyout
`include "fepc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module fepc_top_tb;
	import fepc_pkg::*;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic        busy_in = 1'b0;
	logic        double_err_evt = 1'b0;
	logic        single_err_evt = 1'b0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        event_pin_out;
	logic        event_pin_oe_n;
	logic        irq;
	logic        pin_level;
	logic [31:0] v;
	int          n_fail = 0;
	int          total_checks = 0;
	int          srcs[3] = '{0, 1, 4};

	always #20 hclk = ~hclk;

	fepc_top u_fepc_top (
		.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.busy_in(busy_in), .double_err_evt(double_err_evt),
		.single_err_evt(single_err_evt), .event_pin_in(pin_level),
		.event_pin_out(event_pin_out), .event_pin_oe_n(event_pin_oe_n), .irq(irq)
	);

	fepc_host_model u_fepc_host_model (
		.pin_out(event_pin_out),
		.pin_oe_n(event_pin_oe_n),
		.pin_level(pin_level)
	);

	task chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			n_fail++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	// signals move by nba on a rising edge; hready and hrdata are read as sampled at that edge
	task bus(input logic w, input logic [7:0] a, input logic [7:0] wd, output logic [31:0] d);
		@(posedge hclk);
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= `FEPC_HTRANS_NSEQ;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		d = hrdata;
		chk(hresp, 32'h0);
	endtask

	// one event of source bit b, then time for record, pin and synchroniser to settle
	task ev(input int b);
		@(posedge hclk);
		if (b == 4) begin
			busy_in <= 1'b1;
			@(posedge hclk);
			busy_in <= 1'b0;
		end else if (b == 1) double_err_evt <= 1'b1;
		else single_err_evt <= 1'b1;
		@(posedge hclk);
		double_err_evt <= 1'b0;
		single_err_evt <= 1'b0;
		repeat (6) @(posedge hclk);
		@(negedge hclk);
	endtask

	task conclude;
		if (n_fail == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	initial begin
		#100000;
		n_fail++;
		conclude;
	end

	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(negedge hclk);
		chk(event_pin_oe_n, 32'h1);
		chk(irq, 32'h0);
		bus(0, `FEPC_PIN_OFS, 8'h00, v);
		chk(v, 32'h1);
		bus(0, `FEPC_CFG_OFS, 8'h00, v);
		chk(v, 32'hff);
		bus(0, `FEPC_REC_OFS, 8'h00, v);
		chk(v, 32'hff);
		bus(0, `FEPC_MASK_OFS, 8'h00, v);
		chk(v, 32'h0);
		bus(1, 8'h10, 8'h5a, v);
		bus(0, 8'h10, 8'h00, v);
		chk(v, 32'h0);
		bus(1, `FEPC_MASK_OFS, 8'hff, v);
		bus(0, `FEPC_MASK_OFS, 8'h00, v);
		chk(v, 32'h13);
		foreach (srcs[i]) ev(srcs[i]);
		chk(event_pin_oe_n, 32'h1);
		bus(0, `FEPC_REC_OFS, 8'h00, v);
		chk(v, 32'hff);
		bus(1, `FEPC_CFG_OFS, 8'h6c, v);
		foreach (srcs[i]) begin
			ev(srcs[i]);
			chk(event_pin_oe_n, 32'h0);
			chk(event_pin_out, 32'h0);
			chk(irq, 32'h1);
			bus(0, `FEPC_REC_OFS, 8'h00, v);
			chk(v, 32'hff & ~(32'h1 << srcs[i]));
			bus(0, `FEPC_PIN_OFS, 8'h00, v);
			chk(v, 32'h0);
			bus(1, `FEPC_REC_OFS, 8'h01 << srcs[i], v);
			repeat (2) @(negedge hclk);
			chk(event_pin_oe_n, 32'h1);
			chk(irq, 32'h0);
		end
		ev(0);
		bus(1, `FEPC_CFG_OFS, 8'hec, v);
		bus(0, `FEPC_REC_OFS, 8'h00, v);
		chk(v, 32'hfe);
		ev(1);
		chk(event_pin_oe_n, 32'h1);
		chk(irq, 32'h1);
		bus(0, `FEPC_REC_OFS, 8'h00, v);
		chk(v, 32'hfc);
		bus(1, `FEPC_MASK_OFS, 8'h00, v);
		repeat (2) @(negedge hclk);
		chk(irq, 32'h0);
		bus(1, `FEPC_REC_OFS, 8'h13, v);
		bus(0, `FEPC_REC_OFS, 8'h00, v);
		chk(v, 32'hff);
		conclude;
	end
endmodule
`default_nettype wire
